// File: iox_expander.sv
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "iox_defines.svh"

// Operation
// R1 - a transfer starts when select falls, and serial output and serial input begin together then.
// R2 - at the select falling edge the twelve parallel pin levels are captured into the output shifter.
// R3 - the captured bits leave on the serial output, a new bit presented at each link clock falling edge.
// R4 - the serial input is sampled on each link clock rising edge into the input shifter, twelve per transfer.
// R5 - the thirteenth and later clocks are ignored, serial input is dropped and serial output floats.
// R6 - at the select rising edge the twelve received bits go to the output latch driving the pins.
// R7 - if select rises early the latch still takes the input shifter contents and later activity is ignored.
// R8 - each captured pin bit is the AND of the pin level and that pin's output latch bit.
// R9 - a latch one releases its open-drain pin as an input, a zero drives it low.
// R10 - while force-release is low the serial output and all parallel pins float.
// R11 - the input shifter and the output shifter work independently and at the same time.
// R12 - a clock counter cleared at select fall picks the shifted bit and finds the thirteenth clock.
// R13 - while select is high clock and serial input are ignored, serial output floats, the latch holds.
module iox_expander
  import iox_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  input  wire logic [`IOX_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`IOX_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [31:0]            s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   selectN,
  input  wire logic                   linkClk,
  input  wire logic                   serialIn,
  input  wire logic                   releaseN,
  input  wire logic [`IOX_BITS-1:0]   pinIn,
  output var  logic                   serialOut,
  output var  logic                   serialOe,
  output var  logic [`IOX_BITS-1:0]   pinOut,
  output var  logic [`IOX_BITS-1:0]   pinOe
);

  logic [`IOX_SYNC_W-1:0]  syncBus;
  logic [`IOX_BITS-1:0]    pinS;
  logic                    selS;
  logic                    clkS;
  logic                    dinS;
  logic                    relS;
  logic                    selPrev;
  logic                    clkPrev;
  logic                    selFall;
  logic                    selRise;
  logic                    clkRise;
  logic                    clkFall;
  iox_link_e               linkState;
  logic [3:0]              bitCnt;
  logic [`IOX_BITS-1:0]    shiftOut;
  logic [`IOX_BITS-1:0]    shiftIn;
  logic [`IOX_BITS-1:0]    outLatch;
  logic [`IOX_BITS-1:0]    capWord;
  logic                    startOk;
  logic                    latchLoad;
  logic                    ctrlEnable;
  logic                    overflow;
  logic                    fifoInReady;
  logic [`IOX_BITS-1:0]    fifoData;
  logic                    fifoValid;
  logic                    fifoPop;
  logic [`IOX_LEVEL_W-1:0] fifoLevel;
  logic                    awHeld;
  logic                    wHeld;
  logic [`IOX_ADDR_W-1:0]  awAddr;
  logic [31:0]             wData;
  logic [3:0]              wStrb;
  logic                    awTake;
  logic                    wTake;
  logic                    arTake;
  logic                    doWrite;
  logic                    next_awHeld;
  logic                    next_wHeld;
  logic                    next_rBusy;
  logic [`IOX_ADDR_W-1:0]  wAlign;
  logic [`IOX_ADDR_W-1:0]  rAlign;
  iox_status_s             statusWord;
  iox_rxword_s             rxWord;

  // pins and link clock come from outside the core clock domain
  iox_sync #(
    .WIDTH(`IOX_SYNC_W)
  ) uSync (
    .core_clk(core_clk),
    .asyncIn ({releaseN, serialIn, linkClk, selectN, pinIn}),
    .syncOut (syncBus)
  );

  assign pinS = syncBus[`IOX_BITS-1:0];
  assign selS = syncBus[`IOX_BITS];
  assign clkS = syncBus[`IOX_BITS+1];
  assign dinS = syncBus[`IOX_BITS+2];
  assign relS = syncBus[`IOX_BITS+3];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      selPrev <= 1'b1;
      clkPrev <= 1'b0;
    end else begin
      selPrev <= selS;
      clkPrev <= clkS;
    end
  end

  assign selFall   = selPrev & ~selS;
  assign selRise   = ~selPrev & selS;
  assign clkRise   = ~clkPrev & clkS;
  assign clkFall   = clkPrev & ~clkS;
  assign capWord   = pinS & outLatch; // [R8]
  assign startOk   = selFall & relS & ctrlEnable & (linkState == LINK_IDLE); // [R1]
  assign latchLoad = selRise & relS & ctrlEnable & (linkState != LINK_IDLE); // [R6] [R7]

  // transfer sequencing and serial output enable
  always_ff @(posedge core_clk) begin
    if (srst || !relS || !ctrlEnable) begin
      linkState <= LINK_IDLE;
      bitCnt    <= 4'd0;
      serialOe  <= 1'b0; // [R10]
    end else begin
      case (linkState)
        LINK_IDLE: begin
          serialOe <= 1'b0; // [R13]
          if (startOk) begin
            linkState <= LINK_XFER;
            bitCnt    <= 4'd0; // [R12]
            serialOe  <= ~capWord[0]; // [R1] [R3]
          end
        end
        LINK_XFER: begin
          if (selRise) begin
            linkState <= LINK_IDLE; // [R7]
            serialOe  <= 1'b0;
          end else if (clkRise && bitCnt != `IOX_CNT_FULL) begin
            bitCnt <= bitCnt + 4'd1; // [R12]
          end else if (clkFall && bitCnt == `IOX_CNT_FULL) begin
            linkState <= LINK_OVER; // [R5]
            serialOe  <= 1'b0;
          end else if (clkFall && bitCnt != 4'd0) begin
            serialOe <= ~shiftOut[1]; // [R3]
          end
        end
        LINK_OVER: begin
          serialOe <= 1'b0; // [R5]
          if (selRise) begin
            linkState <= LINK_IDLE;
          end
        end
        default: begin
          linkState <= LINK_IDLE;
          serialOe  <= 1'b0;
        end
      endcase
    end
  end

  // output shifter, independent of the input shifter
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shiftOut <= '0;
    end else if (startOk) begin
      shiftOut <= capWord; // [R2] [R11]
    end else if (linkState == LINK_XFER && !selRise && !clkRise && clkFall
                 && bitCnt != 4'd0 && bitCnt != `IOX_CNT_FULL) begin
      shiftOut <= {1'b0, shiftOut[`IOX_BITS-1:1]}; // [R3]
    end
  end

  // input shifter, first received bit ends in bit 0 after twelve clocks, in bit 12 minus the clock count on an early select rise
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shiftIn <= '0;
    end else if (linkState == LINK_XFER && relS && ctrlEnable && !selRise
                 && clkRise && bitCnt != `IOX_CNT_FULL) begin
      shiftIn <= {dinS, shiftIn[`IOX_BITS-1:1]}; // [R4] [R11]
    end
  end

  // output latch: ones release every pin
  always_ff @(posedge core_clk) begin
    if (srst || !relS) begin
      outLatch <= '1; // [R10]
    end else if (latchLoad) begin
      outLatch <= shiftIn; // [R6] [R7]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pinOe     <= '0;
      pinOut    <= '0;
      serialOut <= 1'b0;
    end else begin
      pinOe     <= relS ? ~outLatch : '0; // [R9] [R10]
      pinOut    <= '0;
      serialOut <= 1'b0;
    end
  end

  iox_fifo #(
    .WIDTH(`IOX_BITS),
    .DEPTH(`IOX_FIFO_DEPTH),
    .LW   (`IOX_LEVEL_W)
  ) uFifo (
    .core_clk(core_clk),
    .srst    (srst),
    .inData  (shiftIn),
    .inValid (latchLoad),
    .inReady (fifoInReady),
    .outData (fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .level   (fifoLevel)
  );

  // register bus: write path
  assign awTake      = s_axi_awvalid & s_axi_awready;
  assign wTake       = s_axi_wvalid & s_axi_wready;
  assign doWrite     = awHeld & wHeld & ~s_axi_bvalid;
  assign next_awHeld = (awHeld | awTake) & ~doWrite;
  assign next_wHeld  = (wHeld | wTake) & ~doWrite;
  assign wAlign      = {awAddr[`IOX_ADDR_W-1:2], 2'b00};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      awHeld        <= next_awHeld;
      wHeld         <= next_wHeld;
      s_axi_awready <= ~next_awHeld;
      s_axi_wready  <= ~next_wHeld;
    end
  end

  always_ff @(posedge core_clk) begin
    if (awTake) begin
      awAddr <= s_axi_awaddr;
    end
    if (wTake) begin
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IOX_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wAlign == `IOX_CTRL_OFS || wAlign == `IOX_STATUS_OFS
                       || wAlign == `IOX_RXDATA_OFS) ? `IOX_RESP_OKAY : `IOX_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrlEnable <= `IOX_CTRL_RST;
    end else if (doWrite && wAlign == `IOX_CTRL_OFS && wStrb[0]) begin
      ctrlEnable <= wData[`IOX_CTRL_EN_BIT];
    end
  end

  // overflow: word lost when the fifo is full; a new loss wins over a clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      overflow <= 1'b0;
    end else if (latchLoad && !fifoInReady) begin
      overflow <= 1'b1;
    end else if (doWrite && wAlign == `IOX_STATUS_OFS && wStrb[1] && wData[`IOX_STAT_OVF]) begin
      overflow <= 1'b0;
    end
  end

  // register bus: read path
  assign arTake     = s_axi_arvalid & s_axi_arready;
  assign next_rBusy = (s_axi_rvalid & ~s_axi_rready) | arTake;
  assign rAlign     = {s_axi_araddr[`IOX_ADDR_W-1:2], 2'b00};
  assign fifoPop    = arTake & (rAlign == `IOX_RXDATA_OFS) & fifoValid;

  always_comb begin
    statusWord          = '0;
    statusWord.latch    = outLatch;
    statusWord.busy     = (linkState != LINK_IDLE);
    statusWord.overflow = overflow;
    statusWord.level    = fifoLevel;
    rxWord              = '0;
    rxWord.valid        = fifoValid;
    rxWord.data         = fifoValid ? fifoData : '0;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `IOX_RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rBusy;
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        case (rAlign)
          `IOX_CTRL_OFS: begin
            s_axi_rdata <= {31'h0, ctrlEnable};
            s_axi_rresp <= `IOX_RESP_OKAY;
          end
          `IOX_STATUS_OFS: begin
            s_axi_rdata <= statusWord;
            s_axi_rresp <= `IOX_RESP_OKAY;
          end
          `IOX_RXDATA_OFS: begin
            s_axi_rdata <= rxWord;
            s_axi_rresp <= `IOX_RESP_OKAY;
          end
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= `IOX_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence sStart;
    startOk;
  endsequence

  sequence sFirstBit;
    (linkState == LINK_XFER) && (serialOe == ~shiftOut[0]) && (bitCnt == 4'd0);
  endsequence

  a_capture_and: assert property (sStart |=> shiftOut == $past(capWord)) // [R2] [R8]
    else $error("capture is not pin AND latch");
  a_first_bit: assert property (sStart |=> sFirstBit) // [R1] [R3]
    else $error("first serial bit not presented at select fall");
  a_shift_in: assert property (linkState == LINK_XFER && relS && ctrlEnable && !selRise && clkRise
                               && bitCnt < `IOX_CNT_FULL |=> shiftIn[`IOX_BITS-1] == $past(dinS)) // [R4]
    else $error("serial input bit not shifted in");
  a_extra_ignored: assert property (linkState == LINK_OVER |-> !serialOe ##1 $stable(shiftIn)) // [R5]
    else $error("activity after twelve clocks not ignored");
  a_latch_load: assert property (latchLoad |=> outLatch == $past(shiftIn) && linkState == LINK_IDLE) // [R6] [R7]
    else $error("latch did not take received word");
  a_pin_dir: assert property (relS ##1 relS |-> pinOe == ~$past(outLatch)) // [R9]
    else $error("pin direction does not follow latch");
  a_release_float: assert property (!relS |=> !serialOe ##1 (pinOe == '0)) // [R10]
    else $error("outputs not floating under force release");
  a_count_bound: assert property (bitCnt <= `IOX_CNT_FULL) // [R12]
    else $error("clock counter past twelve");
  a_idle_hold: assert property (linkState == LINK_IDLE && relS && !srst && !startOk // [R13]
                                |=> !serialOe && $stable(outLatch))
    else $error("idle link drove output or changed latch");

endmodule

`default_nettype wire

// File: iox_defines.svh
`ifndef IOX_DEFINES_SVH
`define IOX_DEFINES_SVH

// link word
`define IOX_BITS        12
`define IOX_CNT_FULL    4'd12
`define IOX_SYNC_W      16

// fifo between link and register bus
`define IOX_FIFO_DEPTH  4
`define IOX_LEVEL_W     3

// register bus
`define IOX_ADDR_W      8
`define IOX_CTRL_OFS    8'h00
`define IOX_STATUS_OFS  8'h04
`define IOX_RXDATA_OFS  8'h08
`define IOX_CTRL_EN_BIT 0
`define IOX_CTRL_RST    1'b1
`define IOX_STAT_OVF    13
`define IOX_RX_VALID    31
`define IOX_RESP_OKAY   2'b00
`define IOX_RESP_SLVERR 2'b10

`endif

// File: iox_pkg.sv
package iox_pkg;

  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_XFER,
    LINK_OVER
  } iox_link_e;

  typedef struct packed {
    logic [14:0] zero;
    logic [2:0]  level;
    logic        overflow;
    logic        busy;
    logic [11:0] latch;
  } iox_status_s;

  typedef struct packed {
    logic        valid;
    logic [18:0] zero;
    logic [11:0] data;
  } iox_rxword_s;

endpackage

// File: iox_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser; first stage feeds only the second
module iox_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk) begin
    stage1  <= asyncIn;
    syncOut <= stage1;
  end

endmodule

`default_nettype wire

// File: iox_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module iox_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4,
  parameter int LW    = $clog2(DEPTH + 1)
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output var  logic             inReady,
  output var  logic [WIDTH-1:0] outData,
  output var  logic             outValid,
  input  wire logic             outReady,
  output var  logic [LW-1:0]    level
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic             push;
  logic             pop;

  assign inReady  = (level != LW'(DEPTH));
  assign outValid = (level != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wrPtr <= '0;
    end else if (push) begin
      wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + PW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdPtr <= '0;
    end else if (pop) begin
      rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + PW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      level <= '0;
    end else if (push && !pop) begin
      level <= level + LW'(1);
    end else if (pop && !push) begin
      level <= level - LW'(1);
    end
  end

endmodule

`default_nettype wire

// File: iox_host.sv
`timescale 1ns/1ps
`default_nettype none

// host end of the link; the clock idles low and moves inside frames, and once outside them in stray
module iox_host (
  output var  logic selectN,
  output var  logic linkClk,
  output var  logic serialIn,
  input  wire logic serialLine
);
  initial begin
    selectN  = 1'b1;
    linkClk  = 1'b0;
    serialIn = 1'b1;
  end

  // one clock pulse with select high, which the device has to ignore
  task automatic stray();
    serialIn <= ~serialIn;
    #200 linkClk <= 1'b1;
    #200 linkClk <= 1'b0;
    serialIn <= ~serialIn;
    #200;
  endtask

  // data change at each clock fall, read back just before the next fall
  task automatic xfer(input logic [11:0] tx, input int nClk, output logic [11:0] rx, output logic lateHigh);
    rx       = 12'h000;
    lateHigh = 1'b1;
    serialIn <= tx[0];
    #200 selectN <= 1'b0;
    #400;
    for (int i = 0; i < nClk; i++) begin
      linkClk <= 1'b1;
      #190;
      if (i < 12) rx[i] = serialLine;
      else lateHigh &= serialLine;
      #10 linkClk <= 1'b0;
      // past the word the data line keeps toggling
      serialIn <= (i < 11) ? tx[i+1] : ~serialIn;
      #200;
    end
    selectN  <= 1'b1;
    serialIn <= ~serialIn;
    #400;
  endtask
endmodule

`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "iox_defines.svh"

module testbench
  import iox_pkg::*;
;
  typedef struct packed {
    logic [11:0] tx;
    logic [11:0] extLow;
    logic [11:0] expCap;
  } iox_row_s;

  logic        core_clk, srst, releaseN, serialOut, serialOe, selectN, linkClk, serialIn, serialLine, late;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] pinOut, pinOe, extLow, pinLevel, cap, prevLatch;
  int          errorCnt, samplesChecked;
  iox_status_s st;
  iox_row_s    rows [4] = '{'{12'h5a3, 12'h000, 12'hfff}, '{12'hfff, 12'h0f0, 12'h503},
                            '{12'h8c1, 12'hf00, 12'h0ff}, '{12'h000, 12'h001, 12'h8c0}};

  // open-drain pins and serial line with pull-ups
  assign pinLevel   = ~pinOe & ~extLow;
  assign serialLine = ~serialOe;

  iox_expander u_dut (
    .core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .selectN, .linkClk, .serialIn, .releaseN, .pinIn(pinLevel), .serialOut, .serialOe, .pinOut, .pinOe
  );

  iox_host u_host (.selectN, .linkClk, .serialIn, .serialLine);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic closeOut();
    if (errorCnt == 0 && samplesChecked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    bit awDone, wDone;
    awDone = 1'b0;
    wDone  = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge core_clk);
      if (s_axi_awready && !awDone) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !wDone) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rdStat();
    axr(`IOX_STATUS_OFS, rd, resp);
    st = iox_status_s'(rd);
  endtask

  initial begin
    #2_000_000;
    errorCnt++;
    closeOut();
  end

  initial begin
    {srst, releaseN} = 2'b11;
    extLow = 12'h000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    errorCnt       = 0;
    samplesChecked = 0;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("pinOe at reset", pinOe, 32'h0);
    chk("serialOe at reset", serialOe, 32'h0);
    axr(`IOX_CTRL_OFS, rd, resp);
    chk("ctrl", rd[0], 32'h1);
    for (int i = 0; i < 4; i++) begin
      extLow <= rows[i].extLow;
      u_host.xfer(rows[i].tx, 12, cap, late);
      chk("captured word", cap, rows[i].expCap);
      chk("pinOe", pinOe, {20'h0, ~rows[i].tx});
      chk("pinOut", pinOut, 32'h0);
      chk("serialOut", serialOut, 32'h0);
      rdStat();
      chk("busy", st.busy, 32'h0);
      chk("latch", st.latch, rows[i].tx);
      chk("fifo level", st.level, 32'(i + 1));
    end
    // thirteenth and fourteenth clocks, also overflows the full fifo
    extLow <= 12'h000;
    u_host.xfer(12'h3c6, 14, cap, late);
    chk("line released late", late, 32'h1);
    rdStat();
    chk("latch after extra clocks", st.latch, 12'h3c6);
    chk("overflow", st.overflow, 32'h1);
    chk("full level", st.level, 32'h4);
    axw(`IOX_STATUS_OFS, 32'h0000_2000, 4'b0010, resp);
    rdStat();
    chk("overflow cleared", st.overflow, 32'h0);
    for (int i = 0; i < 4; i++) begin
      axr(`IOX_RXDATA_OFS, rd, resp);
      chk("rx word", rd, {1'b1, 19'h0, rows[i].tx});
    end
    axr(`IOX_RXDATA_OFS, rd, resp);
    chk("empty valid", rd[31], 32'h0);
    // select rises after five clocks
    u_host.xfer(12'hb4d, 5, cap, late);
    chk("early captured", cap[4:0], 32'h06);
    chk("serialOe after early end", serialOe, 32'h0);
    rdStat();
    chk("early latch", st.latch[11:7], 32'h0d);
    prevLatch = st.latch;
    u_host.stray();
    rdStat();
    chk("latch after stray clock", st.latch, prevLatch);
    chk("serialOe idle", serialOe, 32'h0);
    axw(`IOX_CTRL_OFS, 32'h0, 4'h1, resp);
    u_host.xfer(12'h0f0, 12, cap, late);
    rdStat();
    chk("latch while disabled", st.latch, prevLatch);
    axw(`IOX_CTRL_OFS, 32'h1, 4'h1, resp);
    chk("ctrl write resp", resp, `IOX_RESP_OKAY);
    axw(8'h0c, 32'hffff_ffff, 4'hf, resp);
    chk("unmapped write resp", resp, `IOX_RESP_SLVERR);
    axr(8'h0c, rd, resp);
    chk("unmapped read resp", resp, `IOX_RESP_SLVERR);
    chk("unmapped read data", rd, 32'h0);
    @(posedge core_clk);
    releaseN <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("pinOe released", pinOe, 32'h0);
    chk("serialOe released", serialOe, 32'h0);
    releaseN <= 1'b1;
    repeat (8) @(posedge core_clk);
    rdStat();
    chk("latch after release", st.latch, 12'hfff);
    closeOut();
  end
endmodule

`default_nettype wire
